// ### verilog/uart_status_pkg.sv
// Shared constants, register map and carrier types for the serial status block
package uart_status_pkg;

  // Timing: bus clock and line rate, sixteen sample ticks per bit
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned BAUD_HZ    = 9_600;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned OS_DIV     = CLK_HZ / (BAUD_HZ * OVERSAMPLE);
  localparam logic [7:0]  OS_DIV_LAST = 8'(OS_DIV - 1);

  // Register byte addresses on the APB
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_DATA   = 12'h004;
  localparam logic [11:0] ADDR_CTRL   = 12'h008;

  // Status bit positions
  localparam int FLAG_TX_EMPTY = 7;
  localparam int FLAG_TX_DONE  = 6;
  localparam int FLAG_RX_FULL  = 5;
  localparam int FLAG_IDLE     = 4;
  localparam int FLAG_OVR      = 3;
  localparam int FLAG_NOISE    = 2;
  localparam int FLAG_FRAMING  = 1;
  localparam int FLAG_PARITY   = 0;

  localparam logic [7:0] FLAGS_RESET = 8'hC0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // Sample points within a bit (sample tick index 0..15)
  localparam logic [3:0] RT_S3   = 4'h3;
  localparam logic [3:0] RT_S5   = 4'h5;
  localparam logic [3:0] RT_S7   = 4'h7;
  localparam logic [3:0] RT_D0   = 4'h8;
  localparam logic [3:0] RT_VOTE = 4'hA;
  localparam logic [3:0] START_RT = 4'h1;

  // Frame lengths: data bits and whole character in bit times
  localparam logic [3:0] DATA_BITS_SHORT = 4'h8;
  localparam logic [3:0] DATA_BITS_LONG  = 4'h9;
  localparam logic [3:0] CHAR_BITS_SHORT = 4'hA;
  localparam logic [3:0] CHAR_BITS_LONG  = 4'hB;
  localparam int         START_MAJORITY  = 4;

  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_done_flag;
    logic rx_buffer_full_flag;
    logic line_idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_flag;
    logic parity_flag;
  } flags_t;

  typedef struct packed {
    logic tx_bit8;
    logic quiet_count_type;
    logic length_sel;
    logic parity_odd;
    logic parity_enable;
    logic rx_full_irq_enable;
    logic tx_enable;
    logic break_queue;
  } ctrl_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

// ### verilog/uart_tx_shifter.sv
// Transmit shifter: sends one prepared frame LSB first at one bit per sixteen ticks
`timescale 1ns/1ps
module uart_tx_shifter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        os_tick,
  input  wire logic        start,
  input  wire logic [10:0] frame,
  input  wire logic [3:0]  nbits,
  output logic             txd,
  output logic             busy
);

  localparam logic [3:0] TICK_LAST = 4'(uart_status_pkg::OVERSAMPLE - 1);

  logic [10:0] shift_q;
  logic [3:0]  left_q;
  logic [3:0]  tick_q;
  logic        busy_q;
  logic        txd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 11'h7FF;
      left_q  <= 4'h0;
      tick_q  <= 4'h0;
      busy_q  <= 1'b0;
      txd_q   <= 1'b1;
    end else if (start && !busy_q) begin
      shift_q <= frame;
      left_q  <= nbits;
      tick_q  <= 4'h0;
      busy_q  <= 1'b1;
      txd_q   <= frame[0];
    end else if (busy_q && os_tick) begin
      tick_q <= tick_q + 4'h1;
      if (tick_q == TICK_LAST) begin
        // Line idles high once the last bit has had its full time
        shift_q <= {1'b1, shift_q[10:1]};
        left_q  <= left_q - 4'h1;
        txd_q   <= (left_q == 4'h1) ? 1'b1 : shift_q[1];
        busy_q  <= (left_q != 4'h1);
      end
    end
  end

  assign txd  = txd_q;
  assign busy = busy_q;

endmodule

// ### verilog/uart_status_flags.sv
// Serial interface status flags, receiver sampling and APB register slave
//
// Summary of operation
// - Status register is read-only; writes ignored, flags cleared by access sequences.
// - Transmit-empty flag sets at reset and when buffer moves to shifter.
// - Status read seeing transmit-empty, then data write, clears it.
// - Done flag sets at reset and when buffer empty and nothing sending.
// - Armed done flag clears on data write, enable rise or break write.
// - Receive-full sets when a character moves into the receive data register.
// - Status read seeing receive-full, then data read, clears it.
// - Idle flag sets after line high one character time, 10 or 11 bits.
// - Quiet type zero counts idle bits right after the start bit.
// - Quiet type one counts idle bits only after the stop bit.
// - Idle clears by read sequence; sets again only after a new character.
// - Overrun sets when new character finds buffer full; new character dropped.
// - Status read seeing overrun, then data read, clears it.
// - Seven start samples, three per bit; disagreement sets noise with receive-full.
// - Status read then data read clears the noise flag.
// - Zero sampled at stop bit sets framing flag with receive-full.
// - Status read seeing framing, then data read, clears it.
// - Parity enabled and mismatched parity bit sets parity flag with receive-full.
// - Status read then data read clears the parity flag.
// - Length select one gives 9-bit characters, zero gives 8-bit.
// - Receive interrupt enabled raises request while receive-full is set.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module uart_status_flags (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             irq
);

  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == uart_status_pkg::ADDR_STATUS) ||
                (addr == uart_status_pkg::ADDR_DATA) ||
                (addr == uart_status_pkg::ADDR_CTRL);
  endfunction

  // Majority of three samples, with a mark when they do not all agree
  function automatic logic [1:0] vote3(input logic [2:0] s);
    vote3 = {~((&s) | ~(|s)), (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2])};
  endfunction

  uart_status_pkg::flags_t    flags_q;
  uart_status_pkg::flags_t    arm_q;
  uart_status_pkg::ctrl_t     ctrl_q;
  uart_status_pkg::ctrl_t     ctrl_wdata;
  uart_status_pkg::rx_state_t rx_state_q;

  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        apb_done;
  logic        status_rd;
  logic        data_rd;
  logic        data_wr;
  logic        ctrl_wr;
  logic        tx_en_rise;
  logic        brk_write;
  logic [31:0] read_mux;

  logic        rx_meta_q;
  logic        rx_sync_q;
  logic [7:0]  os_cnt_q;
  logic        os_tick;
  logic [3:0]  rt_q;
  logic [3:0]  bit_idx_q;
  logic [5:0]  samp_q;
  logic [8:0]  shift_q;
  logic        noise_acc_q;
  logic [3:0]  idle_cnt_q;
  logic        idle_armed_q;
  logic        done_q;
  logic [8:0]  rx_word_q;
  logic        done_noise_q;
  logic        done_framing_q;
  logic        done_parity_q;
  logic [8:0]  rx_data_q;
  logic [1:0]  bit_vote;
  logic [8:0]  rx_word;
  logic [3:0]  data_bits;
  logic [3:0]  char_bits;

  logic [8:0]  tx_buf_q;
  logic        pre_pend_q;
  logic        brk_pend_q;
  logic        brk_req;
  logic        tx_busy;
  logic        tx_go;
  logic        tx_take;
  logic [8:0]  tx_word;
  logic [10:0] tx_frame;

  logic        rx_occupied;
  logic        rx_load;
  logic        empty_clr;
  logic        done_clr;
  logic        done_set;
  logic        idle_set;

  // ---------------- APB slave: one wait state, answer registered ----------------
  assign apb_done   = psel & penable & pready_q;
  assign status_rd  = apb_done & ~pwrite & (paddr == uart_status_pkg::ADDR_STATUS);
  assign data_rd    = apb_done & ~pwrite & (paddr == uart_status_pkg::ADDR_DATA);
  assign data_wr    = apb_done &  pwrite & (paddr == uart_status_pkg::ADDR_DATA);
  assign ctrl_wr    = apb_done &  pwrite & (paddr == uart_status_pkg::ADDR_CTRL);
  assign ctrl_wdata = uart_status_pkg::ctrl_t'(pwdata[7:0]);
  assign tx_en_rise = ctrl_wr & ctrl_wdata.tx_enable & ~ctrl_q.tx_enable;
  assign brk_write  = ctrl_wr & ctrl_wdata.break_queue;

  always_comb begin
    read_mux = 32'h0000_0000;
    if (paddr == uart_status_pkg::ADDR_STATUS) begin
      read_mux[7:0] = flags_q;
    end else if (paddr == uart_status_pkg::ADDR_DATA) begin
      read_mux[8:0] = rx_data_q;
    end else if (paddr == uart_status_pkg::ADDR_CTRL) begin
      read_mux[7:0] = ctrl_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~is_mapped(paddr);
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= read_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= uart_status_pkg::ctrl_t'(uart_status_pkg::CTRL_RESET);
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_wdata;
    end
  end

  // Snapshot of what software saw; flags set after the read are not armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= uart_status_pkg::flags_t'(8'h00);
    end else if (status_rd) begin
      arm_q <= uart_status_pkg::flags_t'(prdata_q[7:0]);
    end else begin
      if (data_rd) begin
        arm_q.rx_buffer_full_flag <= 1'b0;
        arm_q.line_idle_flag      <= 1'b0;
        arm_q.overrun_flag        <= 1'b0;
        arm_q.noise_flag          <= 1'b0;
        arm_q.framing_flag        <= 1'b0;
        arm_q.parity_flag         <= 1'b0;
      end
      if (data_wr) begin
        arm_q.tx_buffer_empty_flag <= 1'b0;
      end
      if (data_wr || tx_en_rise || brk_write) begin
        arm_q.tx_done_flag <= 1'b0;
      end
    end
  end

  // ---------------- Receiver ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rxd;
      rx_sync_q <= rx_meta_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_cnt_q <= 8'h00;
    end else begin
      os_cnt_q <= os_tick ? 8'h00 : os_cnt_q + 8'h01;
    end
  end

  assign os_tick   = (os_cnt_q == uart_status_pkg::OS_DIV_LAST);
  assign data_bits = ctrl_q.length_sel ? uart_status_pkg::DATA_BITS_LONG
                                       : uart_status_pkg::DATA_BITS_SHORT;
  assign char_bits = ctrl_q.length_sel ? uart_status_pkg::CHAR_BITS_LONG
                                       : uart_status_pkg::CHAR_BITS_SHORT;
  assign bit_vote  = vote3({samp_q[1:0], rx_sync_q});
  assign rx_word   = ctrl_q.length_sel ? shift_q : {1'b0, shift_q[8:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q     <= uart_status_pkg::RX_IDLE;
      rt_q           <= 4'h0;
      bit_idx_q      <= 4'h0;
      samp_q         <= 6'h00;
      shift_q        <= 9'h000;
      noise_acc_q    <= 1'b0;
      idle_cnt_q     <= 4'h0;
      done_q         <= 1'b0;
      rx_word_q      <= 9'h000;
      done_noise_q   <= 1'b0;
      done_framing_q <= 1'b0;
      done_parity_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (os_tick) begin
        rt_q <= rt_q + 4'h1;
        unique case (rx_state_q)
          uart_status_pkg::RX_IDLE: begin
            if (!rx_sync_q) begin
              rx_state_q <= uart_status_pkg::RX_START;
              rt_q       <= uart_status_pkg::START_RT;
              samp_q     <= 6'h00;
              idle_cnt_q <= 4'h0;
            end else if (rt_q == uart_status_pkg::RT_VOTE && idle_cnt_q != char_bits) begin
              idle_cnt_q <= idle_cnt_q + 4'h1;
            end
          end
          uart_status_pkg::RX_START: begin
            if (rt_q == uart_status_pkg::RT_S3 || rt_q == uart_status_pkg::RT_S5 ||
                rt_q == uart_status_pkg::RT_S7 ||
                (rt_q >= uart_status_pkg::RT_D0 && rt_q < uart_status_pkg::RT_VOTE)) begin
              samp_q <= {samp_q[4:0], rx_sync_q};
            end
            if (rt_q == uart_status_pkg::RT_VOTE) begin
              // Detection sample was low; the other five plus this one decide
              if ($countones({samp_q, rx_sync_q}) >= uart_status_pkg::START_MAJORITY) begin
                rx_state_q <= uart_status_pkg::RX_IDLE;
              end else begin
                rx_state_q  <= uart_status_pkg::RX_DATA;
                noise_acc_q <= |{samp_q, rx_sync_q};
                bit_idx_q   <= 4'h0;
              end
            end
          end
          uart_status_pkg::RX_DATA: begin
            if (rt_q >= uart_status_pkg::RT_D0 && rt_q < uart_status_pkg::RT_VOTE) begin
              samp_q <= {samp_q[4:0], rx_sync_q};
            end
            if (rt_q == uart_status_pkg::RT_VOTE) begin
              shift_q     <= {bit_vote[0], shift_q[8:1]};
              noise_acc_q <= noise_acc_q | bit_vote[1];
              if (!ctrl_q.quiet_count_type) begin
                // Trailing ones of the character already count as quiet time
                idle_cnt_q <= bit_vote[0] ? idle_cnt_q + 4'h1 : 4'h0;
              end
              bit_idx_q <= bit_idx_q + 4'h1;
              if (bit_idx_q == data_bits - 4'h1) begin
                rx_state_q <= uart_status_pkg::RX_STOP;
              end
            end
          end
          uart_status_pkg::RX_STOP: begin
            if (rt_q >= uart_status_pkg::RT_D0 && rt_q < uart_status_pkg::RT_VOTE) begin
              samp_q <= {samp_q[4:0], rx_sync_q};
            end
            if (rt_q == uart_status_pkg::RT_VOTE) begin
              rx_state_q     <= uart_status_pkg::RX_IDLE;
              done_q         <= 1'b1;
              rx_word_q      <= rx_word;
              done_noise_q   <= noise_acc_q | bit_vote[1];
              done_framing_q <= ~bit_vote[0];
              done_parity_q  <= ctrl_q.parity_enable &
                                ((^rx_word) != ctrl_q.parity_odd);
              if (!ctrl_q.quiet_count_type && bit_vote[0]) begin
                idle_cnt_q <= idle_cnt_q + 4'h1;
              end else begin
                idle_cnt_q <= 4'h0;
              end
            end
          end
        endcase
      end
    end
  end

  // ---------------- Transmit launch ----------------
  assign brk_req = brk_pend_q | ctrl_q.break_queue;
  assign tx_go   = ctrl_q.tx_enable & ~tx_busy &
                   (brk_req | pre_pend_q | ~flags_q.tx_buffer_empty_flag);
  assign tx_take = tx_go & ~brk_req & ~pre_pend_q;

  always_comb begin
    tx_word = tx_buf_q;
    if (ctrl_q.parity_enable && ctrl_q.length_sel) begin
      tx_word[8] = (^tx_buf_q[7:0]) ^ ctrl_q.parity_odd;
    end else if (ctrl_q.parity_enable) begin
      tx_word[7] = (^tx_buf_q[6:0]) ^ ctrl_q.parity_odd;
    end
    if (brk_req) begin
      tx_frame = 11'h000;
    end else if (pre_pend_q) begin
      tx_frame = 11'h7FF;
    end else if (ctrl_q.length_sel) begin
      tx_frame = {1'b1, tx_word, 1'b0};
    end else begin
      tx_frame = {2'b11, tx_word[7:0], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_q   <= 9'h000;
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      if (data_wr) begin
        tx_buf_q <= {ctrl_q.tx_bit8, pwdata[7:0]};
      end
      if (tx_en_rise) begin
        pre_pend_q <= 1'b1;
      end else if (tx_go && !brk_req) begin
        pre_pend_q <= 1'b0;
      end
      if (brk_write) begin
        brk_pend_q <= 1'b1;
      end else if (tx_go) begin
        brk_pend_q <= 1'b0;
      end
    end
  end

  uart_tx_shifter u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .os_tick (os_tick),
    .start   (tx_go),
    .frame   (tx_frame),
    .nbits   (char_bits),
    .txd     (txd),
    .busy    (tx_busy)
  );

  // ---------------- Status flags: set wins over clear, except the done flag ----------------
  assign rx_occupied = flags_q.rx_buffer_full_flag & ~(arm_q.rx_buffer_full_flag & data_rd);
  assign rx_load     = done_q & ~rx_occupied;
  assign empty_clr   = arm_q.tx_buffer_empty_flag & data_wr;
  assign done_clr    = arm_q.tx_done_flag & (data_wr | tx_en_rise | brk_write);
  // The clearing event itself starts new activity, so it also blocks the set
  assign done_set    = flags_q.tx_buffer_empty_flag & ~empty_clr & ~tx_busy & ~tx_go &
                       ~pre_pend_q & ~brk_req & ~done_clr;
  assign idle_set    = idle_armed_q & (idle_cnt_q == char_bits);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= uart_status_pkg::flags_t'(uart_status_pkg::FLAGS_RESET);
    end else begin
      flags_q.tx_buffer_empty_flag <= tx_take | (flags_q.tx_buffer_empty_flag & ~empty_clr);
      flags_q.tx_done_flag         <= done_set | (flags_q.tx_done_flag & ~done_clr);
      flags_q.rx_buffer_full_flag  <= rx_load | rx_occupied;
      flags_q.line_idle_flag       <= idle_set | (flags_q.line_idle_flag &
                                      ~(arm_q.line_idle_flag & data_rd));
      flags_q.overrun_flag         <= (done_q & rx_occupied) | (flags_q.overrun_flag &
                                      ~(arm_q.overrun_flag & data_rd));
      flags_q.noise_flag           <= (rx_load & done_noise_q) | (flags_q.noise_flag &
                                      ~(arm_q.noise_flag & data_rd));
      flags_q.framing_flag         <= (rx_load & done_framing_q) | (flags_q.framing_flag &
                                      ~(arm_q.framing_flag & data_rd));
      flags_q.parity_flag          <= (rx_load & done_parity_q) | (flags_q.parity_flag &
                                      ~(arm_q.parity_flag & data_rd));
    end
  end

  // Idle may fire once per received character, however long the line rests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_armed_q <= 1'b0;
      rx_data_q    <= 9'h000;
    end else begin
      if (rx_load) begin
        idle_armed_q <= 1'b1;
        rx_data_q    <= rx_word_q;
      end else if (idle_set) begin
        idle_armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flags_q.rx_buffer_full_flag & ctrl_q.rx_full_irq_enable;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_data_read;
    apb_done && !pwrite && (paddr == uart_status_pkg::ADDR_DATA);
  endsequence
  sequence s_data_write;
    apb_done && pwrite && (paddr == uart_status_pkg::ADDR_DATA);
  endsequence
  sequence s_status_write;
    apb_done && pwrite && (paddr == uart_status_pkg::ADDR_STATUS);
  endsequence

  a_status_read_only: assert property (
    (s_status_write ##0 flags_q.rx_buffer_full_flag && !data_rd)
      |=> flags_q.rx_buffer_full_flag && !pslverr_q)
    else $error("status write disturbed a flag");
  a_empty_on_take: assert property (tx_take |=> flags_q.tx_buffer_empty_flag)
    else $error("buffer empty flag not set on transfer");
  a_empty_clear_seq: assert property (
    (s_data_write ##0 arm_q.tx_buffer_empty_flag) |=> !flags_q.tx_buffer_empty_flag)
    else $error("buffer empty flag not cleared by sequence");
  a_done_set_idle: assert property (
    done_set |=> flags_q.tx_done_flag)
    else $error("done flag not set while idle");
  a_done_clear_seq: assert property (done_clr |=> !flags_q.tx_done_flag)
    else $error("done flag not cleared by sequence");
  a_full_load_data: assert property (
    (done_q && !rx_occupied) |=> flags_q.rx_buffer_full_flag && rx_data_q == $past(rx_word_q))
    else $error("received character not loaded");
  a_full_clear_seq: assert property (
    (s_data_read ##0 arm_q.rx_buffer_full_flag && !done_q) |=> !flags_q.rx_buffer_full_flag)
    else $error("receive full not cleared by sequence");
  a_idle_once_only: assert property ($rose(flags_q.line_idle_flag) |-> $past(idle_armed_q))
    else $error("idle flag set without a new character");
  a_overrun_drop: assert property (
    (done_q && rx_occupied) |=> flags_q.overrun_flag && $stable(rx_data_q))
    else $error("overrun not flagged or data overwritten");
  a_framing_with_full: assert property (
    (done_q && !rx_occupied && done_framing_q)
      |=> flags_q.framing_flag && flags_q.rx_buffer_full_flag)
    else $error("framing error not flagged with receive full");
  a_irq_follows_full: assert property (
    (flags_q.rx_buffer_full_flag && ctrl_q.rx_full_irq_enable) |=> irq_q)
    else $error("receive interrupt missing");
  a_arm_only_seen: assert property (
    (apb_done && !pwrite && (paddr == uart_status_pkg::ADDR_STATUS)
      ##0 !prdata_q[uart_status_pkg::FLAG_RX_FULL]) |=> !arm_q.rx_buffer_full_flag)
    else $error("unseen flag armed for clearing");

endmodule

// ### tb/uart_remote_model.sv
// Remote serial device that drives the receive line
`timescale 1ns/1ps
module uart_remote_model (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  localparam int BIT_CLKS = 16 * uart_status_pkg::OS_DIV;
  initial rxd = 1'b1;
  // Start bit, eight data bits LSB first, stop bit at the given level, then idle high
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  // Waits for a start bit on the transmit line, samples each of ten bits at its middle
  task automatic catch_frame(output logic [9:0] f);
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd;
      repeat (BIT_CLKS) @(posedge pclk);
    end
  endtask
endmodule

// ### tb/uart_status_flags_bench.sv
// Self-checking bench for the serial status flags block
`timescale 1ns/1ps
module uart_status_flags_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, rxd, txd, irq, er;
  logic [7:0]  st;
  logic [9:0]  tf;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  always #25 pclk = ~pclk;
  uart_status_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  uart_remote_model rem (.pclk(pclk), .txd(txd), .rxd(rxd));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rdst();
    apb(0, 12'h000, 0);
    st = rd[7:0];
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bound on the whole run, a little above the four frames it needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdst(); chk("reset status", st, 8'hC0);
    apb(1, 12'h000, 32'hFF);
    rdst(); chk("status after write", st, 8'hC0);
    apb(0, 12'h010, 0); chk("unmapped err", er, 1); chk("unmapped data", rd, 0);
    $display("registers done");
    apb(1, 12'h008, 32'h6);
    rdst(); chk("enable clears done", st[7:6], 2'b10);
    apb(1, 12'h004, 32'h41);
    rdst(); chk("write clears empty", st[7:6], 2'b00);
    $display("transmit done");
    fork
      begin
        rem.send(8'h5A, 1);
        repeat (20000) @(posedge pclk);
      end
      rem.catch_frame(tf);
    join
    chk("tx frame", tf, 10'h282);
    rdst(); chk("full and idle", st[5:0], 6'h30);
    chk("tx idle again", st[7:6], 2'b11);
    chk("irq high", irq, 1);
    apb(1, 12'h000, 32'h0);
    rdst(); chk("status write kept", st[5:4], 2'b11);
    apb(0, 12'h004, 0); chk("rx data", rd[8:0], 9'h05A);
    rdst(); chk("cleared", st[5:0], 6'h00);
    chk("irq low", irq, 0);
    apb(1, 12'h008, 32'h1F);
    rdst(); chk("break clears done", st[7:6], 2'b10);
    apb(1, 12'h008, 32'h1E);
    rem.send(8'h33, 0);
    repeat (200) @(posedge pclk);
    rdst(); chk("framing", {st[7:5], st[3:0]}, 7'b1110011);
    rem.send(8'h0F, 1);
    repeat (200) @(posedge pclk);
    rdst(); chk("overrun", {st[5], st[3:0]}, 5'b11011);
    apb(0, 12'h004, 0); chk("kept data", rd[8:0], 9'h033);
    rdst(); chk("errors cleared", st[5:0], 6'h00);
    $display("receive done");
    finish_test();
  end
endmodule
